// >>> design/system_control_regs.sv
`timescale 1ns/1ps
module system_control_regs #(
  parameter logic [31:0] DEB_LONG = sysctl_pkg::DEB_LONG_CYCLES,
  parameter logic [31:0] DEB_SHORT = sysctl_pkg::DEB_SHORT_CYCLES,
  parameter logic [31:0] WDOG_BASE = sysctl_pkg::WDOG_BASE_CYCLES
) (
  // Clock and resets
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sm_reset_in,
  // Register port from the control interface
  input wire sysctl_pkg::reg_req_t reg_req_in,
  output logic [15:0] reg_rdata_out,
  // Chip state
  input wire logic security_unlocked_in,
  input wire logic hibernate_in,
  input wire logic memory_reset_out_n_in,
  input wire sysctl_pkg::usb_events_t usb_events_in,
  // Pins
  input wire logic button_pin_in,
  input wire logic keepalive_input_in,
  input wire logic irq_request_in,
  output logic irq_pin_out,
  // Control outputs
  output sysctl_pkg::usb_ctrl_t usb_ctrl_out,
  output logic memory_valid_out,
  output logic chip_configured_out,
  output logic shutdown_request_out,
  output logic watchdog_timeout_event_out,
  output logic watchdog_reset_event_out,
  output logic system_reset_out
);
  import sysctl_pkg::*;

  regs_state_t state_ff;
  regs_state_t nxt_state;
  logic write_one;
  logic write_two;
  logic [15:0] wd;
  logic button_active;
  logic keepalive_edge;
  logic wdog_reload;
  watchdog_mode_sel_t watchdog_mode_sel_eff;

  assign write_one = reg_req_in.write && reg_req_in.addr == ADDR_CTRL_ONE;
  assign write_two = reg_req_in.write && reg_req_in.addr == ADDR_CTRL_TWO;
  assign wd = reg_req_in.wdata;

  // Polarity 1 makes a low pin the active level
  assign button_active = button_pin_in ^ state_ff.button_pol;

  assign keepalive_edge = keepalive_input_in ^ state_ff.keepalive_prev;
  assign wdog_reload = keepalive_edge || write_two;

  // Hibernate without the enable stops the watchdog outright
  always_comb
  begin
    if (hibernate_in && !state_ff.wdog_hib_enable)
      watchdog_mode_sel_eff = WDOG_OFF;
    else
      watchdog_mode_sel_eff = state_ff.watchdog_mode_sel;
  end

  always_comb
  begin
    nxt_state = state_ff;
    nxt_state.keepalive_prev = keepalive_input_in;
    nxt_state.irq_pin = irq_request_in ^ ~state_ff.irq_pin_polarity;

    if (write_one)
    begin
      nxt_state.mem_valid = wd[C1_MEM_VALID];
      nxt_state.chip_set_up = wd[C1_CHIP_SET_UP];
      nxt_state.irq_pin_polarity = wd[C1_IRQ_PIN_POLARITY];
      if (security_unlocked_in)
      begin
        nxt_state.debug_halt = wd[C1_DEBUG_HALT];
        nxt_state.debounce_sel = wd[C1_DEBOUNCE_SEL];
        nxt_state.button_pol = wd[C1_BUTTON_POL];
      end
    end

    if (write_two)
    begin
      nxt_state.usb.low_current_suspend = wd[C2_LOW_CUR_SUSPEND];
      nxt_state.usb.suspend = wd[C2_USB_SUSPEND];
      nxt_state.usb.role_master = wd[C2_ROLE_MASTER];
      nxt_state.usb.master_source_sel = wd[C2_MASTER_SRC];
      nxt_state.usb.master_high_current = wd[C2_MASTER_HIGH];
      nxt_state.usb.limit_disable = wd[C2_LIMIT_DISABLE];
      nxt_state.usb.slave_high_current = wd[C2_SLAVE_HIGH];
      nxt_state.wdog_hib_enable = wd[C2_WDOG_HIB_EN];
      if (security_unlocked_in)
      begin
        nxt_state.watchdog_mode_sel = watchdog_mode_sel_t'(wd[C2_WATCHDOG_MODE_SEL_LSB +: 2]);
        // Reserved timeout codes leave the old setting in place
        if (wd[C2_WATCHDOG_TIMEOUT_SEL_LSB +: 3] <= WATCHDOG_TIMEOUT_SEL_MAX)
          nxt_state.wdog_timeout = wd[C2_WATCHDOG_TIMEOUT_SEL_LSB +: 3];
      end
    end

    // Hardware clears override a write in the same cycle
    if (!memory_reset_out_n_in)
      nxt_state.mem_valid = 1'b0;
    if (usb_events_in.undervoltage || usb_events_in.boot_fail)
    begin
      nxt_state.usb.low_current_suspend = 1'b0;
      nxt_state.usb.suspend = 1'b0;
      nxt_state.usb.slave_high_current = 1'b0;
    end
    if (usb_events_in.master_to_slave)
      nxt_state.usb.role_master = 1'b0;

    if (reg_req_in.read)
    begin
      nxt_state.rdata = '0;
      if (reg_req_in.addr == ADDR_CTRL_ONE)
      begin
        nxt_state.rdata[C1_DEBUG_HALT] = state_ff.debug_halt;
        nxt_state.rdata[C1_MEM_VALID] = state_ff.mem_valid;
        nxt_state.rdata[C1_CHIP_SET_UP] = state_ff.chip_set_up;
        nxt_state.rdata[C1_DEBOUNCE_SEL] = state_ff.debounce_sel;
        nxt_state.rdata[C1_BUTTON_POL] = state_ff.button_pol;
        nxt_state.rdata[C1_IRQ_PIN_POLARITY] = state_ff.irq_pin_polarity;
      end
      else if (reg_req_in.addr == ADDR_CTRL_TWO)
      begin
        nxt_state.rdata[C2_LOW_CUR_SUSPEND] = state_ff.usb.low_current_suspend;
        nxt_state.rdata[C2_USB_SUSPEND] = state_ff.usb.suspend;
        nxt_state.rdata[C2_ROLE_MASTER] = state_ff.usb.role_master;
        nxt_state.rdata[C2_MASTER_SRC] = state_ff.usb.master_source_sel;
        nxt_state.rdata[C2_MASTER_HIGH] = state_ff.usb.master_high_current;
        nxt_state.rdata[C2_LIMIT_DISABLE] = state_ff.usb.limit_disable;
        nxt_state.rdata[C2_SLAVE_HIGH] = state_ff.usb.slave_high_current;
        nxt_state.rdata[C2_WDOG_HIB_EN] = state_ff.wdog_hib_enable;
        nxt_state.rdata[C2_WATCHDOG_MODE_SEL_LSB +: 2] = state_ff.watchdog_mode_sel;
        nxt_state.rdata[C2_WATCHDOG_TIMEOUT_SEL_LSB +: 3] = state_ff.wdog_timeout;
      end
    end

    // State-machine reset: only the fields it owns
    if (sm_reset_in)
    begin
      nxt_state.button_pol = REGS_RESET.button_pol;
      nxt_state.irq_pin_polarity = REGS_RESET.irq_pin_polarity;
      nxt_state.usb.role_master = 1'b0;
      nxt_state.usb.master_source_sel = 1'b0;
      nxt_state.usb.master_high_current = 1'b0;
      nxt_state.usb.slave_high_current = 1'b0;
      nxt_state.watchdog_mode_sel = REGS_RESET.watchdog_mode_sel;
    end

    if (rst_in)
      nxt_state = REGS_RESET;
  end

  always_ff @(posedge clock_in)
  begin
    state_ff <= nxt_state;
  end

  button_debounce #(
    .LONG_CYCLES(DEB_LONG),
    .SHORT_CYCLES(DEB_SHORT)
  ) u_debounce (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .active_in(button_active),
    .short_sel_in(state_ff.debounce_sel),
    .shutdown_out(shutdown_request_out)
  );

  watchdog_timer #(
    .BASE_CYCLES(WDOG_BASE)
  ) u_watchdog (
    .clock_in(clock_in),
    .rst_in(rst_in),
    .mode_in(watchdog_mode_sel_eff),
    // Next value, so a write to control two reloads with the new timeout
    .timeout_sel_in(nxt_state.wdog_timeout),
    .halt_in(state_ff.debug_halt),
    .reload_in(wdog_reload),
    .timeout_event_out(watchdog_timeout_event_out),
    .reset_event_out(watchdog_reset_event_out)
  );

  assign system_reset_out = watchdog_reset_event_out;
  assign reg_rdata_out = state_ff.rdata;
  assign irq_pin_out = state_ff.irq_pin;
  assign usb_ctrl_out = state_ff.usb;
  assign memory_valid_out = state_ff.mem_valid;
  assign chip_configured_out = state_ff.chip_set_up;
endmodule // system_control_regs

// >>> pkg/sysctl_pkg.sv
package sysctl_pkg;

  // Register map
  localparam logic [7:0] ADDR_CTRL_ONE = 8'h03;
  localparam logic [7:0] ADDR_CTRL_TWO = 8'h04;

  // Control one fields
  localparam int C1_DEBUG_HALT = 7;
  localparam int C1_MEM_VALID = 5;
  localparam int C1_CHIP_SET_UP = 4;
  localparam int C1_DEBOUNCE_SEL = 3;
  localparam int C1_BUTTON_POL = 1;
  localparam int C1_IRQ_PIN_POLARITY = 0;

  // Control two fields
  localparam int C2_LOW_CUR_SUSPEND = 15;
  localparam int C2_USB_SUSPEND = 14;
  localparam int C2_ROLE_MASTER = 13;
  localparam int C2_MASTER_SRC = 12;
  localparam int C2_MASTER_HIGH = 11;
  localparam int C2_LIMIT_DISABLE = 10;
  localparam int C2_SLAVE_HIGH = 9;
  localparam int C2_WDOG_HIB_EN = 7;
  localparam int C2_WATCHDOG_MODE_SEL_LSB = 4;
  localparam int C2_WATCHDOG_TIMEOUT_SEL_LSB = 0;

  // Reset values and the largest valid timeout code
  localparam logic RST_BUTTON_POL = 1'b1;
  localparam logic RST_IRQ_PIN_POLARITY = 1'b0;
  localparam logic [2:0] RST_WATCHDOG_TIMEOUT_SEL = 3'h4;
  localparam logic [2:0] WATCHDOG_TIMEOUT_SEL_MAX = 3'h5;

  // Timing
  localparam longint unsigned CLK_HZ = 125_000_000;
  localparam longint unsigned DEB_LONG_S = 10;
  localparam longint unsigned DEB_SHORT_S = 5;
  localparam longint unsigned WDOG_BASE_MS = 125;
  localparam logic [31:0] DEB_LONG_CYCLES = 32'(DEB_LONG_S * CLK_HZ);
  localparam logic [31:0] DEB_SHORT_CYCLES = 32'(DEB_SHORT_S * CLK_HZ);
  localparam logic [31:0] WDOG_BASE_CYCLES = 32'(WDOG_BASE_MS * CLK_HZ / 1000);

  typedef enum logic [1:0] {
    WDOG_OFF = 2'b00,
    WDOG_TIMEOUT = 2'b01,
    WDOG_RESET = 2'b10,
    WDOG_TWO_STAGE = 2'b11
  } watchdog_mode_sel_t;

  typedef struct packed {
    logic [7:0] addr;
    logic write;
    logic read;
    logic [15:0] wdata;
  } reg_req_t;

  typedef struct packed {
    logic low_current_suspend;
    logic suspend;
    logic role_master;
    logic master_source_sel;
    logic master_high_current;
    logic limit_disable;
    logic slave_high_current;
  } usb_ctrl_t;

  typedef struct packed {
    logic undervoltage;
    logic boot_fail;
    logic master_to_slave;
  } usb_events_t;

  typedef struct packed {
    logic debug_halt;
    logic mem_valid;
    logic chip_set_up;
    logic debounce_sel;
    logic button_pol;
    logic irq_pin_polarity;
    usb_ctrl_t usb;
    logic wdog_hib_enable;
    watchdog_mode_sel_t watchdog_mode_sel;
    logic [2:0] wdog_timeout;
    logic [15:0] rdata;
    logic keepalive_prev;
    logic irq_pin;
  } regs_state_t;

  localparam regs_state_t REGS_RESET = '{
    debug_halt: 1'b0, mem_valid: 1'b0, chip_set_up: 1'b0, debounce_sel: 1'b0,
    button_pol: RST_BUTTON_POL, irq_pin_polarity: RST_IRQ_PIN_POLARITY, usb: '0,
    wdog_hib_enable: 1'b0, watchdog_mode_sel: WDOG_OFF, wdog_timeout: RST_WATCHDOG_TIMEOUT_SEL,
    rdata: 16'h0000, keepalive_prev: 1'b0, irq_pin: ~RST_IRQ_PIN_POLARITY};

endpackage

// >>> design/button_debounce.sv
`timescale 1ns/1ps
module button_debounce #(
  parameter logic [31:0] LONG_CYCLES = sysctl_pkg::DEB_LONG_CYCLES,
  parameter logic [31:0] SHORT_CYCLES = sysctl_pkg::DEB_SHORT_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Button
  input wire logic active_in,
  input wire logic short_sel_in,
  output logic shutdown_out
);
  import sysctl_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic fired;
    logic pulse;
  } deb_state_t;

  deb_state_t state_ff;
  deb_state_t nxt_state;
  logic [31:0] limit;

  always_comb
  begin
    limit = short_sel_in ? SHORT_CYCLES : LONG_CYCLES;
    nxt_state = state_ff;
    nxt_state.pulse = 1'b0;
    if (!active_in)
    begin
      nxt_state.count = '0;
      nxt_state.fired = 1'b0;
    end
    else if (!state_ff.fired)
    begin
      if (state_ff.count >= limit - 32'h1)
      begin
        nxt_state.pulse = 1'b1;
        nxt_state.fired = 1'b1;
      end
      else
      begin
        nxt_state.count = state_ff.count + 32'h1;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
      state_ff <= '0;
    else
      state_ff <= nxt_state;
  end

  assign shutdown_out = state_ff.pulse;
endmodule // button_debounce

// >>> design/watchdog_timer.sv
`timescale 1ns/1ps
module watchdog_timer #(
  parameter logic [31:0] BASE_CYCLES = sysctl_pkg::WDOG_BASE_CYCLES
) (
  // Clock and reset
  input wire logic clock_in,
  input wire logic rst_in,
  // Control
  input wire sysctl_pkg::watchdog_mode_sel_t mode_in,
  input wire logic [2:0] timeout_sel_in,
  input wire logic halt_in,
  input wire logic reload_in,
  // Events
  output logic timeout_event_out,
  output logic reset_event_out
);
  import sysctl_pkg::*;

  typedef struct packed {
    logic [31:0] count;
    logic strike;
    logic timeout_event;
    logic reset_event;
  } wd_state_t;

  wd_state_t state_ff;
  wd_state_t nxt_state;
  logic [31:0] period;

  always_comb
  begin
    period = BASE_CYCLES << timeout_sel_in;
    nxt_state = state_ff;
    nxt_state.timeout_event = 1'b0;
    nxt_state.reset_event = 1'b0;
    if (mode_in == WDOG_OFF || reload_in)
    begin
      nxt_state.count = period;
      nxt_state.strike = 1'b0;
    end
    else if (!halt_in)
    begin
      if (state_ff.count <= 32'h1)
      begin
        nxt_state.count = period;
        unique case (mode_in)
          WDOG_OFF: ;
          WDOG_TIMEOUT: nxt_state.timeout_event = 1'b1;
          WDOG_RESET: nxt_state.reset_event = 1'b1;
          WDOG_TWO_STAGE:
          begin
            nxt_state.timeout_event = !state_ff.strike;
            nxt_state.reset_event = state_ff.strike;
            nxt_state.strike = !state_ff.strike;
          end
        endcase
      end
      else
      begin
        nxt_state.count = state_ff.count - 32'h1;
      end
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (rst_in)
    begin
      state_ff <= '0;
      state_ff.count <= BASE_CYCLES << RST_WATCHDOG_TIMEOUT_SEL;
    end
    else
    begin
      state_ff <= nxt_state;
    end
  end

  assign timeout_event_out = state_ff.timeout_event;
  assign reset_event_out = state_ff.reset_event;
endmodule // watchdog_timer

// >>> verification/system_control_regs_props.sv
`timescale 1ns/1ps
module system_control_regs_props (
  // Clock and resets
  input wire logic clock_in,
  input wire logic rst_in,
  input wire logic sm_reset_in,
  // Inputs watched
  input wire sysctl_pkg::reg_req_t reg_req_in,
  input wire logic memory_reset_out_n_in,
  input wire sysctl_pkg::usb_events_t usb_events_in,
  // Outputs watched
  input wire sysctl_pkg::usb_ctrl_t usb_ctrl_out,
  input wire logic irq_pin_out,
  input wire logic memory_valid_out,
  input wire logic chip_configured_out,
  input wire logic shutdown_request_out,
  input wire logic watchdog_timeout_event_out,
  input wire logic watchdog_reset_event_out,
  input wire logic system_reset_out
);
  import sysctl_pkg::*;
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (rst_in);
  AST_MEM_CLEAR:
    assert property (!memory_reset_out_n_in |=> !memory_valid_out)
    else $error("memory valid set during memory reset");
  AST_RST_DEFAULTS:
    assert property ($fell(rst_in) |-> irq_pin_out && usb_ctrl_out == '0 && !chip_configured_out)
    else $error("wrong state after reset");
  AST_USB_CLEAR:
    assert property ((usb_events_in.undervoltage || usb_events_in.boot_fail) |=>
      !(usb_ctrl_out.low_current_suspend || usb_ctrl_out.suspend || usb_ctrl_out.slave_high_current))
    else $error("usb bits not cleared by fault");
  AST_ROLE_CLEAR:
    assert property (usb_events_in.master_to_slave |=> !usb_ctrl_out.role_master)
    else $error("role not cleared");
  AST_SM_RESET:
    assert property (sm_reset_in |=> !(usb_ctrl_out.role_master || usb_ctrl_out.master_source_sel
      || usb_ctrl_out.master_high_current || usb_ctrl_out.slave_high_current))
    else $error("usb bits kept over state machine reset");
  AST_CFG_HOLD:
    assert property (!(reg_req_in.write && reg_req_in.addr == ADDR_CTRL_ONE)
      |=> $stable(chip_configured_out))
    else $error("configured flag changed without write");
  AST_NOLIM_HOLD:
    assert property (!(reg_req_in.write && reg_req_in.addr == ADDR_CTRL_TWO)
      |=> $stable(usb_ctrl_out.limit_disable))
    else $error("limit disable changed without write");
  AST_SYS_RST:
    assert property (watchdog_reset_event_out |-> system_reset_out ##1 !watchdog_reset_event_out)
    else $error("reset event not a single pulse with system reset");
  AST_RELOAD:
    assert property ((reg_req_in.write && reg_req_in.addr == ADDR_CTRL_TWO)
      |-> ##2 !watchdog_timeout_event_out [*2])
    else $error("timeout soon after reload");
  AST_SHUT_PULSE:
    assert property (shutdown_request_out |=> !shutdown_request_out)
    else $error("shutdown pulse too long");
  cover property (watchdog_timeout_event_out);
  cover property (watchdog_reset_event_out);
  cover property (shutdown_request_out);
endmodule // system_control_regs_props

// >>> verification/host_model.sv
`timescale 1ns/1ps
module host_model (
  // Clock
  input wire logic clock_in,
  // Register port
  output sysctl_pkg::reg_req_t reg_req_out,
  input wire logic [15:0] rdata_in,
  // Keepalive_input
  output logic beat_out
);
  import sysctl_pkg::*;
  initial
  begin
    reg_req_out = '0;
    beat_out = 1'b0;
  end
  // One access; released lines show inverted values
  task automatic access(input logic [7:0] a, input logic w, input logic [15:0] d,
                        output logic [15:0] q);
    @(negedge clock_in);
    reg_req_out = '{addr: a, write: w, read: ~w, wdata: d};
    @(negedge clock_in);
    reg_req_out = '{addr: ~a, write: 1'b0, read: 1'b0, wdata: ~d};
    q = rdata_in;
  endtask
  task automatic keep_alive(input int n);
    repeat (n)
    begin
      repeat (2) @(negedge clock_in);
      beat_out = ~beat_out;
    end
  endtask
endmodule // host_model

// >>> verification/system_control_regs_tb_top.sv
`timescale 1ns/1ps
module system_control_regs_tb_top;
  import sysctl_pkg::*;
  logic clock_in, rst_in, sm_reset_in, unl, hib, memory_reset_out_n_n, button, irq_req, beat;
  logic irq_pin, mem_valid, cfg, shut, wto, wrst, sys_rst;
  logic [15:0] rdata, c1, c2, q, te, re, sh, rs;
  usb_events_t ev;
  reg_req_t req;
  usb_ctrl_t usb;
  int error_cnt, total_checks, cyc;
  system_control_regs #(.DEB_LONG(32'h28), .DEB_SHORT(32'h14), .WDOG_BASE(32'h4)) DUT (
    .clock_in(clock_in), .rst_in(rst_in), .sm_reset_in(sm_reset_in), .reg_req_in(req),
    .reg_rdata_out(rdata), .security_unlocked_in(unl), .hibernate_in(hib),
    .memory_reset_out_n_in(memory_reset_out_n_n), .usb_events_in(ev), .button_pin_in(button),
    .keepalive_input_in(beat), .irq_request_in(irq_req), .irq_pin_out(irq_pin),
    .usb_ctrl_out(usb), .memory_valid_out(mem_valid), .chip_configured_out(cfg),
    .shutdown_request_out(shut), .watchdog_timeout_event_out(wto),
    .watchdog_reset_event_out(wrst), .system_reset_out(sys_rst));
  host_model HOST (.clock_in(clock_in), .reg_req_out(req), .rdata_in(rdata), .beat_out(beat));
  initial
  begin
    clock_in = 1'b0;
    forever #4 clock_in = ~clock_in;
  end
  always @(posedge clock_in)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      error_cnt++;
      wrap_up();
    end
  end
  function automatic logic [15:0] merge(input logic [15:0] old, d, m);
    return (old & ~m) | (d & m);
  endfunction
  task automatic wrap_up();
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clock_in);
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    logic [15:0] m;
    HOST.access(a, 1'b1, d, q);
    m = unl ? 16'hfeb7 : 16'hfe80;
    if (d[2:1] == 2'b11)
      m[2:0] = 3'h0;
    if (a == ADDR_CTRL_ONE)
      c1 = merge(c1, d, unl ? 16'h00bb : 16'h0031);
    if (a == ADDR_CTRL_TWO)
      c2 = merge(c2, d, m);
  endtask
  task automatic rd(input logic [7:0] a);
    HOST.access(a, 1'b0, 16'h0, q);
    chk(q, a == ADDR_CTRL_ONE ? c1 : a == ADDR_CTRL_TWO ? c2 : 16'h0);
    chk(16'(usb), 16'(c2[15:9]));
    chk(16'({mem_valid, cfg}), 16'(c1[5:4]));
  endtask
  task automatic count(input int n);
    te = '0;
    re = '0;
    sh = '0;
    rs = '0;
    repeat (n)
    begin
      @(posedge clock_in);
      #1;
      te = te + 16'(wto);
      re = re + 16'(wrst);
      sh = sh + 16'(shut);
      rs = rs + 16'(sys_rst);
    end
  endtask
  initial
  begin
    {rst_in, sm_reset_in, unl, hib, memory_reset_out_n_n, button, irq_req} = 7'b1000110;
    ev = '0;
    c1 = 16'h0002;
    c2 = 16'h0004;
    void'($urandom(13009));
    tick(8);
    rst_in = 1'b0;
    rd(8'h03);
    rd(8'h04);
    rd(8'h07);
    // Random traffic, locked and unlocked, unmapped included
    for (int i = 0; i < 24; i++)
    begin
      unl = 1'($urandom);
      wr(8'($urandom_range(3, 5)), 16'($urandom));
      rd(8'h03);
      rd(8'h04);
    end
    unl = 1'b1;
    // Fault events clear their usb bits
    for (int k = 0; k < 3; k++)
    begin
      wr(8'h04, 16'hfe80);
      ev = usb_events_t'(3'h4 >> k);
      tick(1);
      ev = '0;
      c2 &= (k == 2) ? 16'hdfff : 16'h3dff;
      rd(8'h04);
    end
    wr(8'h03, 16'h0032);
    memory_reset_out_n_n = 1'b0;
    tick(1);
    memory_reset_out_n_n = 1'b1;
    c1 &= 16'hffdf;
    rd(8'h03);
    wr(8'h03, 16'h0031);
    wr(8'h04, 16'hfe97);
    sm_reset_in = 1'b1;
    tick(1);
    sm_reset_in = 1'b0;
    c1 = (c1 & 16'hfffc) | 16'h0002;
    c2 &= 16'hc5cf;
    rd(8'h03);
    rd(8'h04);
    wr(8'h03, 16'h0010);
    rst_in = 1'b1;
    tick(1);
    rst_in = 1'b0;
    c1 = 16'h0002;
    c2 = 16'h0004;
    rd(8'h03);
    for (int p = 0; p < 2; p++)
    begin
      wr(8'h03, 16'(p) | 16'h0002);
      irq_req = 1'b1;
      tick(2);
      chk(16'(irq_pin), 16'(p));
      irq_req = 1'b0;
      tick(2);
      chk(16'(irq_pin), 16'(1 - p));
    end
    // Button: polarity, debounce select, short and long holds
    for (int k = 0; k < 4; k++)
    begin
      wr(8'h03, {12'h0, 1'(k >> 1), 1'b0, 1'(k), 1'b0});
      button = 1'(k);
      tick(4);
      button = ~1'(k);
      count(k == 0 ? 50 : 30);
      tick(1);
      button = 1'(k);
      chk(sh, 16'(k == 0 || k >= 2));
    end
    wr(8'h03, 16'h0002);
    button = 1'b1;
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h04, 16'(m << 4));
      count(40);
      chk(16'(te != 0), 16'(m & 1));
      chk(16'(re != 0), 16'(m >> 1));
      chk(rs, re);
    end
    wr(8'h04, 16'h0012);
    count(12);
    chk(te, 16'h0);
    count(8);
    chk(te, 16'h1);
    wr(8'h04, 16'h0010);
    fork
      HOST.keep_alive(20);
      count(40);
    join
    chk(te, 16'h0);
    hib = 1'b1;
    wr(8'h04, 16'h0010);
    count(40);
    chk(te, 16'h0);
    wr(8'h04, 16'h0090);
    count(40);
    chk(16'(te != 0), 16'h1);
    tick(1);
    hib = 1'b0;
    wr(8'h03, 16'h0082);
    wr(8'h04, 16'h0010);
    count(40);
    chk(te, 16'h0);
    wrap_up();
  end
endmodule // system_control_regs_tb_top

bind system_control_regs system_control_regs_props PROPS (
  .clock_in(clock_in), .rst_in(rst_in), .sm_reset_in(sm_reset_in), .reg_req_in(reg_req_in),
  .memory_reset_out_n_in(memory_reset_out_n_in), .usb_events_in(usb_events_in),
  .usb_ctrl_out(usb_ctrl_out), .irq_pin_out(irq_pin_out), .memory_valid_out(memory_valid_out),
  .chip_configured_out(chip_configured_out), .shutdown_request_out(shutdown_request_out),
  .watchdog_timeout_event_out(watchdog_timeout_event_out),
  .watchdog_reset_event_out(watchdog_reset_event_out), .system_reset_out(system_reset_out));
